//--- common/hdlc_rx_defs.svh
`ifndef HDLC_RX_DEFS_SVH
`define HDLC_RX_DEFS_SVH

// Command codes and decode groups
`define CMD_RESET      8'hFF
`define CMD_LOAD_FC    8'h80
`define CMD_LOAD_STP   8'h81
`define CMD_LOAD_RTP   8'h86
`define CMD_GRP_MASK   8'hE0
`define CMD_GRP_STN    8'hA0
`define CMD_GRP_HW     8'hC0

// Semaphore values
`define SEM_BUSY       8'hFE
`define SEM_DONE       8'hFF

// Reset values
`define IVR_RESET      8'h0F

// Hardware configuration field positions
`define HW_NRZI_BIT    4
`define HW_BURST_BIT   3
`define HW_ORDER_BIT   1
`define HW_WIDTH_BIT   0

// Descriptor word 0 field positions
`define D0_EOT_BIT     15
`define D0_LINK_BIT    7

// Descriptor geometry in bytes
`define WORD_BYTES     32'h00000002
`define DESC_BYTES     32'h0000000A
`define D4_OFS         32'h00000008

// Station table offsets (bytes)
`define ST_RTP_OFS     32'h00000010
`define ST_RX_ERR_OFS  32'h00000040

// Receive status bits
`define RXST_ERR_BIT   0
`define RXST_ILL_BIT   1
`define RXST_OVF_BIT   2

`endif

//--- common/hdlc_rx_pkg.sv
package hdlc_rx_pkg;

  // Receive side sequencer
  typedef enum logic [2:0] {
    S_IDLE  = 3'h0,
    S_RST   = 3'h1,
    S_DESC  = 3'h2,
    S_LINK  = 3'h3,
    S_ARMED = 3'h4,
    S_STORE = 3'h5,
    S_FINAL = 3'h6,
    S_ERRW  = 3'h7
  } state_t;

  // One bus master cycle
  typedef struct packed {
    logic        we;
    logic [3:0]  fc;
    logic [31:0] addr;
    logic [15:0] wdata;
    logic        upper_lane;
  } mem_req_t;

  // Station and hardware configuration
  typedef struct packed {
    logic long_crc_select;
    logic wide_control_select;
    logic nrzi_select;
    logic burst_limit_select;
    logic byte_order_select;
    logic bus_width_select;
  } cfg_t;

endpackage : hdlc_rx_pkg

//--- src/hdlc_cmd_rx.sv
`timescale 1ns/1ps
`include "hdlc_rx_defs.svh"
module hdlc_cmd_rx #(
  parameter int unsigned LONG_CRC_SELECT_BIT  = 1,
  parameter int unsigned WIDE_CONTROL_SELECT_BIT  = 0,
  parameter logic [3:0]  BURST_LEN = 4'h8
) (
  input  wire logic                    clk_i,
  input  wire logic                    nrst_i,
  input  wire logic                    cmd_wr_i,
  input  wire logic [7:0]              cmd_i,
  input  wire logic [31:0]             data_i,
  input  wire logic                    tx_clk_running_i,
  input  wire logic [31:0]             st_rx_table_ptr_i,
  input  wire logic [3:0]              st_rx_table_fc_i,
  input  wire logic                    mem_ack_i,
  input  wire logic                    mem_err_i,
  input  wire logic [15:0]             mem_rdata_i,
  input  wire logic                    rx_byte_valid_i,
  input  wire logic [7:0]              rx_byte_i,
  input  wire logic                    rx_frame_end_i,
  output logic [7:0]                   semaphore_o,
  output logic                         mem_req_o,
  output hdlc_rx_pkg::mem_req_t        mem_o,
  output hdlc_rx_pkg::cfg_t            cfg_o,
  output logic [7:0]                   int_vector_o,
  output logic [3:0]                   station_fc_o,
  output logic [31:0]                  station_ptr_o,
  output logic [2:0]                   rx_status_o,
  output logic                         rx_enable_o,
  output logic                         line_idle_o,
  output logic                         rx_byte_ready_o
);

  hdlc_rx_pkg::state_t   state_reg;
  hdlc_rx_pkg::cfg_t     cfg_reg;
  hdlc_rx_pkg::mem_req_t mem_reg;
  logic [7:0]            sem_reg;
  logic [7:0]            ivr_reg;
  logic [31:0]           stp_reg;
  logic [3:0]            stfc_reg;
  logic [31:0]           rtp_reg;
  logic [3:0]            rtfc_reg;
  logic [31:0]           rbp_reg;
  logic [3:0]            bfc_reg;
  logic [15:0]           rbc_reg;
  logic [15:0]           offs_reg;
  logic                  eot_reg;
  logic                  link_reg;
  logic [1:0]            widx_reg;
  logic                  req_reg;
  logic                  gap_reg;
  logic [3:0]            burst_reg;
  logic                  rx_en_reg;
  logic                  idle_reg;
  logic [2:0]            rxst_reg;
  logic [7:0]            byte_reg;
  logic [3:0]            err_fc_reg;
  logic [31:0]           err_addr_reg;

  // Force even addresses on a 16-bit bus; odd pointers never fault
  function automatic logic [31:0] bus_addr(input logic [31:0] a, input logic bus16);
    bus_addr = bus16 ? {a[31:1], 1'b0} : a;
  endfunction : bus_addr

  // Word address inside a table
  function automatic logic [31:0] word_addr(input logic [31:0] base, input logic [1:0] idx);
    word_addr = base + {29'h0, idx, 1'b0};
  endfunction : word_addr

  // Build one bus cycle
  function automatic hdlc_rx_pkg::mem_req_t mk_req(input logic we, input logic [3:0] fc,
                                                   input logic [31:0] addr, input logic [15:0] wd,
                                                   input logic up);
    mk_req = '{we: we, fc: fc, addr: addr, wdata: wd, upper_lane: up};
  endfunction : mk_req

  // Command decode
  wire cmd_take  = cmd_wr_i && (sem_reg == `SEM_DONE);
  wire is_reset  = cmd_i == `CMD_RESET;
  wire is_rtp    = cmd_i == `CMD_LOAD_RTP;
  wire is_stn    = (cmd_i & `CMD_GRP_MASK) == `CMD_GRP_STN;
  wire is_hw     = (cmd_i & `CMD_GRP_MASK) == `CMD_GRP_HW;
  wire soft_rst  = (state_reg == hdlc_rx_pkg::S_RST) && tx_clk_running_i;
  wire clr       = !nrst_i || soft_rst;

  // Bus cycle completion and error
  wire cyc_done  = req_reg && (mem_ack_i || mem_err_i);
  wire cyc_err   = req_reg && mem_err_i;
  wire can_issue = !req_reg && !gap_reg;
  wire burst_end = cfg_reg.burst_limit_select && (burst_reg == BURST_LEN - 4'h1);

  // Address sources per state
  wire [31:0] desc_addr = word_addr(rtp_reg, widx_reg);
  wire [31:0] link_addr = word_addr(stp_reg + `ST_RTP_OFS, widx_reg);
  wire [31:0] errw_addr = word_addr(stp_reg + `ST_RX_ERR_OFS, widx_reg);
  wire [31:0] byte_addr = bus_addr(rbp_reg, cfg_reg.bus_width_select) + {16'h0, offs_reg};
  wire        byte_up   = cfg_reg.bus_width_select && (byte_addr[0] == cfg_reg.byte_order_select);
  wire [15:0] errw_data = (widx_reg == 2'h0) ? {12'h0, err_fc_reg} :
                          (widx_reg == 2'h1) ? err_addr_reg[31:16] :
                          (widx_reg == 2'h2) ? err_addr_reg[15:0] : {13'h0, rxst_reg};

  // Bus arbitration: bursts capped when the limit bit is set
  always_ff @(posedge clk_i) begin
    if (clr || !req_reg) begin
      gap_reg <= 1'b0;
    end else if (cyc_done) begin
      gap_reg <= burst_end;
    end
  end

  always_ff @(posedge clk_i) begin
    if (clr || gap_reg) begin
      burst_reg <= 4'h0;
    end else if (cyc_done) begin
      burst_reg <= burst_end ? 4'h0 : burst_reg + 4'h1;
    end
  end

  // Host command side: configuration and station registers
  always_ff @(posedge clk_i) begin
    if (clr) begin
      cfg_reg  <= '0;
      ivr_reg  <= `IVR_RESET;
      stp_reg  <= 32'h0;
      stfc_reg <= 4'h0;
      idle_reg <= 1'b1;
    end else if (cmd_take) begin
      if (is_stn) begin
        cfg_reg.long_crc_select     <= cmd_i[LONG_CRC_SELECT_BIT];
        cfg_reg.wide_control_select <= cmd_i[WIDE_CONTROL_SELECT_BIT];
      end
      if (is_hw) begin
        cfg_reg.nrzi_select        <= cmd_i[`HW_NRZI_BIT];
        cfg_reg.burst_limit_select <= cmd_i[`HW_BURST_BIT];
        cfg_reg.byte_order_select  <= cmd_i[`HW_ORDER_BIT];
        cfg_reg.bus_width_select   <= cmd_i[`HW_WIDTH_BIT];
      end
      if (cmd_i == `CMD_LOAD_FC) begin
        stfc_reg <= data_i[3:0];
      end
      if (cmd_i == `CMD_LOAD_STP) begin
        stp_reg <= data_i;
      end
    end
  end

  // Receive sequencer; semaphore closes where each command ends
  always_ff @(posedge clk_i) begin
    if (clr) begin
      state_reg <= hdlc_rx_pkg::S_IDLE;
      sem_reg   <= `SEM_DONE;
      req_reg   <= 1'b0;
      mem_reg   <= '0;
      rtp_reg   <= 32'h0;
      rtfc_reg  <= 4'h0;
      rbp_reg   <= 32'h0;
      bfc_reg   <= 4'h0;
      rbc_reg   <= 16'h0;
      offs_reg  <= 16'h0;
      eot_reg   <= 1'b0;
      link_reg  <= 1'b0;
      widx_reg  <= 2'h0;
      rx_en_reg <= 1'b0;
      rxst_reg  <= 3'h0;
      byte_reg  <= 8'h0;
      err_fc_reg   <= 4'h0;
      err_addr_reg <= 32'h0;
    end else if (cmd_take && is_reset) begin
      // Bus dropped at once; the clear waits for the transmit clock
      sem_reg   <= `SEM_BUSY;
      req_reg   <= 1'b0;
      state_reg <= hdlc_rx_pkg::S_RST;
    end else begin
      if (cmd_take) begin
        sem_reg <= `SEM_BUSY;
      end else if (sem_reg == `SEM_BUSY && state_reg != hdlc_rx_pkg::S_DESC
                   && state_reg != hdlc_rx_pkg::S_LINK && state_reg != hdlc_rx_pkg::S_ERRW
                   && state_reg != hdlc_rx_pkg::S_RST) begin
        sem_reg <= `SEM_DONE;
      end
      if (cyc_done) begin
        req_reg <= 1'b0;
      end
      if (cyc_err && state_reg != hdlc_rx_pkg::S_ERRW) begin
        // Table disabled and the faulting cycle logged
        err_fc_reg   <= mem_reg.fc;
        err_addr_reg <= mem_reg.addr;
        rxst_reg[`RXST_ERR_BIT] <= 1'b1;
        rx_en_reg    <= 1'b0;
        widx_reg     <= 2'h0;
        state_reg    <= hdlc_rx_pkg::S_ERRW;
      end else begin
        unique case (state_reg)
          hdlc_rx_pkg::S_IDLE, hdlc_rx_pkg::S_ARMED: begin
            if (cmd_take && is_rtp && rx_en_reg) begin
              rxst_reg[`RXST_ILL_BIT] <= 1'b1;  // Buffers still free
            end else if (cmd_take && is_rtp) begin
              rtp_reg   <= st_rx_table_ptr_i;
              rtfc_reg  <= st_rx_table_fc_i;
              rx_en_reg <= 1'b1;
              widx_reg  <= 2'h0;
              state_reg <= hdlc_rx_pkg::S_DESC;
            end else if (state_reg == hdlc_rx_pkg::S_ARMED && rx_frame_end_i) begin
              state_reg <= hdlc_rx_pkg::S_FINAL;
            end else if (state_reg == hdlc_rx_pkg::S_ARMED && rx_byte_valid_i) begin
              if (rbc_reg != 16'h0) begin
                byte_reg  <= rx_byte_i;
                state_reg <= hdlc_rx_pkg::S_STORE;
              end else begin
                rxst_reg[`RXST_OVF_BIT] <= 1'b1;  // Buffer full, byte dropped
              end
            end
          end
          hdlc_rx_pkg::S_RST: begin
            // Held here until the transmit clock runs
          end
          hdlc_rx_pkg::S_DESC: begin
            if (can_issue) begin
              req_reg <= 1'b1;
              mem_reg <= mk_req(1'b0, rtfc_reg, desc_addr, 16'h0, 1'b0);
            end
            if (cyc_done) begin
              unique case (widx_reg)
                2'h0: begin
                  bfc_reg  <= mem_rdata_i[3:0];
                  link_reg <= mem_rdata_i[`D0_LINK_BIT];
                  eot_reg  <= mem_rdata_i[`D0_EOT_BIT];
                end
                2'h1: rbp_reg[31:16] <= mem_rdata_i;
                2'h2: rbp_reg[15:0]  <= mem_rdata_i;
                2'h3: rbc_reg        <= mem_rdata_i;
              endcase
              widx_reg <= widx_reg + 2'h1;
              if (widx_reg == 2'h3) begin
                offs_reg  <= 16'h0;
                state_reg <= hdlc_rx_pkg::S_ARMED;
              end
            end
          end
          hdlc_rx_pkg::S_LINK: begin
            if (can_issue) begin
              req_reg <= 1'b1;
              mem_reg <= mk_req(1'b0, stfc_reg, link_addr, 16'h0, 1'b0);
            end
            if (cyc_done) begin
              // Next table pointer and code from the station table
              if (widx_reg == 2'h0) begin
                rtfc_reg <= mem_rdata_i[3:0];
              end
              if (widx_reg == 2'h1) begin
                rtp_reg[31:16] <= mem_rdata_i;
              end
              if (widx_reg == 2'h2) begin
                rtp_reg[15:0] <= mem_rdata_i;
                state_reg     <= hdlc_rx_pkg::S_DESC;
              end
              widx_reg <= (widx_reg == 2'h2) ? 2'h0 : widx_reg + 2'h1;
            end
          end
          hdlc_rx_pkg::S_STORE: begin
            if (can_issue) begin
              req_reg <= 1'b1;
              mem_reg <= mk_req(1'b1, bfc_reg, byte_addr, {byte_reg, byte_reg}, byte_up);
            end
            if (cyc_done) begin
              offs_reg  <= offs_reg + 16'h1;
              rbc_reg   <= rbc_reg - 16'h1;
              state_reg <= hdlc_rx_pkg::S_ARMED;
            end
          end
          hdlc_rx_pkg::S_FINAL: begin
            if (can_issue) begin
              req_reg <= 1'b1;
              mem_reg <= mk_req(1'b1, rtfc_reg, rtp_reg + `D4_OFS, rbc_reg, 1'b0);
            end
            if (cyc_done) begin
              widx_reg <= 2'h0;
              if (!eot_reg) begin
                rtp_reg   <= rtp_reg + `DESC_BYTES;
                state_reg <= hdlc_rx_pkg::S_DESC;
              end else if (link_reg) begin
                state_reg <= hdlc_rx_pkg::S_LINK;
              end else begin
                rx_en_reg <= 1'b0;
                state_reg <= hdlc_rx_pkg::S_IDLE;
              end
            end
          end
          hdlc_rx_pkg::S_ERRW: begin
            // A second fault here abandons the log to avoid looping
            if (can_issue) begin
              req_reg <= 1'b1;
              mem_reg <= mk_req(1'b1, stfc_reg, errw_addr, errw_data, 1'b0);
            end
            if (cyc_done) begin
              widx_reg <= widx_reg + 2'h1;
              if (widx_reg == 2'h3 || cyc_err) begin
                sem_reg   <= `SEM_DONE;
                state_reg <= hdlc_rx_pkg::S_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

  // Outputs
  assign semaphore_o     = sem_reg;
  assign mem_req_o       = req_reg;
  assign mem_o           = mem_reg;
  assign cfg_o           = cfg_reg;
  assign int_vector_o    = ivr_reg;
  assign station_fc_o    = stfc_reg;
  assign station_ptr_o   = stp_reg;
  assign rx_status_o     = rxst_reg;
  assign rx_enable_o     = rx_en_reg;
  assign line_idle_o     = idle_reg;
  assign rx_byte_ready_o = state_reg == hdlc_rx_pkg::S_ARMED;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  a_sem_accept: assert property (cmd_take |=> sem_reg == `SEM_BUSY)
    else $error("semaphore not busy after accept");
  a_sem_simple: assert property (cmd_take && (is_stn || is_hw) |=> ##1 sem_reg == `SEM_DONE)
    else $error("simple command did not complete");
  a_reset_wait: assert property (state_reg == hdlc_rx_pkg::S_RST && !tx_clk_running_i
                                 |=> state_reg == hdlc_rx_pkg::S_RST)
    else $error("reset ran without transmit clock");
  a_reset_bus: assert property (cmd_take && is_reset |=> !mem_req_o)
    else $error("bus held after reset command");
  a_reset_vals: assert property (soft_rst |=> ivr_reg == `IVR_RESET && cfg_reg == '0 && rtp_reg == 32'h0
                                 && !rx_en_reg && sem_reg == `SEM_DONE)
    else $error("reset values wrong");
  a_hw_config: assert property (cmd_take && is_hw |=> cfg_reg.nrzi_select == $past(cmd_i[4])
                                && cfg_reg.bus_width_select == $past(cmd_i[0]))
    else $error("hardware config not loaded");
  a_stn_config: assert property (cmd_take && is_stn |=> cfg_reg.long_crc_select == $past(cmd_i[LONG_CRC_SELECT_BIT]))
    else $error("station config not loaded");
  a_even_addr: assert property (req_reg && mem_reg.we && state_reg == hdlc_rx_pkg::S_STORE
                                && cfg_reg.bus_width_select && offs_reg == 16'h0 |-> !mem_reg.addr[0])
    else $error("odd first address on 16-bit bus");
  a_count_down: assert property (state_reg == hdlc_rx_pkg::S_STORE && cyc_done && !cyc_err
                                 |=> rbc_reg == $past(rbc_reg) - 16'h1)
    else $error("byte counter not decremented");
  a_final_word: assert property (state_reg == hdlc_rx_pkg::S_FINAL && req_reg
                                 |-> mem_reg.we && mem_reg.wdata == rbc_reg)
    else $error("final count not written");
  a_buf_code: assert property (state_reg == hdlc_rx_pkg::S_STORE && req_reg |-> mem_reg.fc == bfc_reg)
    else $error("buffer function code wrong");
  a_err_stop: assert property (cyc_err && state_reg != hdlc_rx_pkg::S_ERRW
                               |=> state_reg == hdlc_rx_pkg::S_ERRW && !rx_en_reg)
    else $error("error did not stop reception");
  a_burst_gap: assert property (req_reg && burst_end && cyc_done |=> !req_reg ##1 !req_reg)
    else $error("burst not broken");

  c_rtp_load: cover property (cmd_take && is_rtp ##[1:20] state_reg == hdlc_rx_pkg::S_ARMED);
  c_frame: cover property (state_reg == hdlc_rx_pkg::S_FINAL ##[1:10] state_reg == hdlc_rx_pkg::S_DESC);
  c_bus_err: cover property (state_reg == hdlc_rx_pkg::S_ERRW);
  c_soft_rst: cover property (soft_rst);

endmodule : hdlc_cmd_rx

//--- verif/hdlc_mem_model.sv
`timescale 1ns/1ps
module hdlc_mem_model (
  input  wire logic                  clk_i,
  input  wire logic                  nrst_i,
  input  wire logic                  mem_req_i,
  input  wire hdlc_rx_pkg::mem_req_t mem_i,
  input  wire logic [1:0]            wait_i,
  input  wire logic                  err_en_i,
  input  wire logic [31:0]           err_addr_i,
  output logic                       mem_ack_o,
  output logic                       mem_err_o,
  output logic [15:0]                mem_rdata_o
);
  logic [15:0] mem      [0:63];
  logic [31:0] log_addr [0:15];
  logic [15:0] log_data [0:15];
  logic [3:0]  log_fc   [0:15];
  logic        log_up   [0:15];
  int          log_n;
  logic [1:0]  wait_reg;

  // Answer once the programmed wait runs out, never twice per cycle
  wire busy = mem_ack_o | mem_err_o;
  wire hit  = mem_req_i & ~busy & (wait_reg == wait_i);
  wire bad  = err_en_i & (mem_i.addr == err_addr_i);

  // Read data rots outside an answer so stale values never pass
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      mem_ack_o   <= 1'b0;
      mem_err_o   <= 1'b0;
      wait_reg    <= 2'h0;
      log_n       <= 0;
      mem_rdata_o <= 16'h0000;
    end else begin
      mem_ack_o   <= hit & ~bad;
      mem_err_o   <= hit & bad;
      wait_reg    <= (mem_req_i & ~busy & ~hit) ? wait_reg + 2'h1 : 2'h0;
      mem_rdata_o <= (hit & ~mem_i.we) ? mem[mem_i.addr[6:1]] : ~mem_rdata_o;
      // Only completed writes are logged
      if (hit & mem_i.we & ~bad) begin
        log_addr[log_n[3:0]] <= mem_i.addr;
        log_data[log_n[3:0]] <= mem_i.wdata;
        log_fc[log_n[3:0]]   <= mem_i.fc;
        log_up[log_n[3:0]]   <= mem_i.upper_lane;
        log_n                <= log_n + 1;
      end
    end
  end
endmodule : hdlc_mem_model

//--- verif/hdlc_cmd_rx_tb.sv
`timescale 1ns/1ps
module hdlc_cmd_rx_tb;
  logic                  clk_i = 1'b0;
  logic                  nrst_i = 1'b0;
  logic                  cmd_wr_i = 1'b0;
  logic [7:0]            cmd_i = 8'h00;
  logic [31:0]           data_i = 32'h00000000;
  logic                  tx_clk_running_i = 1'b1;
  logic [31:0]           st_ptr = 32'h00000000;
  logic [3:0]            st_fc = 4'h0;
  logic                  rx_byte_valid_i = 1'b0;
  logic [7:0]            rx_byte_i = 8'h00;
  logic                  rx_frame_end_i = 1'b0;
  logic [1:0]            wait_n = 2'h0;
  logic                  err_en = 1'b0;
  logic [31:0]           err_addr = 32'h00000000;
  logic                  mem_ack, mem_err, mem_req_o, rx_enable_o, line_idle_o, rx_byte_ready_o;
  logic [15:0]           mem_rdata;
  logic [7:0]            semaphore_o, int_vector_o;
  logic [3:0]            station_fc_o;
  logic [31:0]           station_ptr_o;
  logic [2:0]            rx_status_o;
  hdlc_rx_pkg::mem_req_t mem_w;
  hdlc_rx_pkg::cfg_t     cfg_o;
  int                    errors = 0;
  int                    checks = 0;
  logic [7:0]            cfg_cmd [4] = '{8'hA3, 8'hBC, 8'hD9, 8'hC6};
  logic [5:0]            cfg_exp [4] = '{6'h30, 6'h00, 6'h0D, 6'h02};

  hdlc_cmd_rx hdlc_cmd_rx_inst (.clk_i(clk_i), .nrst_i(nrst_i), .cmd_wr_i(cmd_wr_i), .cmd_i(cmd_i),
    .data_i(data_i), .tx_clk_running_i(tx_clk_running_i), .st_rx_table_ptr_i(st_ptr),
    .st_rx_table_fc_i(st_fc), .mem_ack_i(mem_ack), .mem_err_i(mem_err), .mem_rdata_i(mem_rdata),
    .rx_byte_valid_i(rx_byte_valid_i), .rx_byte_i(rx_byte_i), .rx_frame_end_i(rx_frame_end_i),
    .semaphore_o(semaphore_o), .mem_req_o(mem_req_o), .mem_o(mem_w), .cfg_o(cfg_o),
    .int_vector_o(int_vector_o), .station_fc_o(station_fc_o), .station_ptr_o(station_ptr_o),
    .rx_status_o(rx_status_o), .rx_enable_o(rx_enable_o), .line_idle_o(line_idle_o),
    .rx_byte_ready_o(rx_byte_ready_o));

  hdlc_mem_model mem_model_inst (.clk_i(clk_i), .nrst_i(nrst_i), .mem_req_i(mem_req_o), .mem_i(mem_w),
    .wait_i(wait_n), .err_en_i(err_en), .err_addr_i(err_addr), .mem_ack_o(mem_ack),
    .mem_err_o(mem_err), .mem_rdata_o(mem_rdata));

  // Free running 100 MHz clock
  always #5 clk_i = ~clk_i;

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check

  task test_done;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  // One host command; next one only after the semaphore says done
  task send(input logic [7:0] c, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cmd_i    <= c;
    data_i   <= d;
    cmd_wr_i <= 1'b1;
    @(posedge clk_i);
    cmd_wr_i <= 1'b0;
    #1 check(semaphore_o, 8'hFE);
    n = 0;
    while (semaphore_o !== 8'hFF && n < 300) begin
      @(posedge clk_i);
      #1 n++;
    end
    check(semaphore_o, 8'hFF);
  endtask : send

  // Offers a byte or a frame end and holds it until the edge that takes it
  task rx_put(input logic fin, input logic [7:0] b);
    int n;
    n = 0;
    @(posedge clk_i);
    rx_byte_valid_i <= ~fin;
    rx_frame_end_i  <= fin;
    rx_byte_i       <= b;
    #1;
    // Ready seen settled here still stands at the next edge
    while (rx_byte_ready_o !== 1'b1 && n < 100) begin
      @(posedge clk_i);
      #1 n++;
    end
    @(posedge clk_i);
    rx_byte_valid_i <= 1'b0;
    rx_frame_end_i  <= 1'b0;
  endtask : rx_put

  task wait_log(input int k);
    int n;
    n = 0;
    while (mem_model_inst.log_n < k && n < 300) begin
      @(posedge clk_i);
      #1 n++;
    end
    check(mem_model_inst.log_n, k);
  endtask : wait_log

  task chk_log(input int i, input logic [31:0] a, input logic [15:0] d);
    check(mem_model_inst.log_addr[i], a);
    check(mem_model_inst.log_data[i], d);
  endtask : chk_log

  // Hang guard, well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    test_done();
  end

  // Last descriptor, not linked, odd buffer 0x53 on an 8-bit bus, 3 bytes
  initial begin
    mem_model_inst.mem[16] = 16'h8005;
    mem_model_inst.mem[17] = 16'h0000;
    mem_model_inst.mem[18] = 16'h0053;
    mem_model_inst.mem[19] = 16'h0003;
    // Last descriptor, linked, even buffer 0x60 for the 16-bit bus, 3 bytes
    mem_model_inst.mem[24] = 16'h8086;
    mem_model_inst.mem[25] = 16'h0000;
    mem_model_inst.mem[26] = 16'h0060;
    mem_model_inst.mem[27] = 16'h0003;
    // Next table pointer entry in the station table: code 9, table at 0x40
    mem_model_inst.mem[8]  = 16'h0009;
    mem_model_inst.mem[9]  = 16'h0000;
    mem_model_inst.mem[10] = 16'h0040;
    mem_model_inst.mem[32] = 16'h8007;
    mem_model_inst.mem[33] = 16'h0000;
    mem_model_inst.mem[34] = 16'h0070;
    mem_model_inst.mem[35] = 16'h0004;
  end

  initial begin
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    #1 check(semaphore_o, 8'hFF);
    check(int_vector_o, 8'h0F);
    check(mem_req_o, 1'b0);
    check(line_idle_o, 1'b1);
    check(cfg_o, 6'h00);
    $display("test reset_values done");
    for (int i = 0; i < 4; i++) begin
      send(cfg_cmd[i], 32'h00000000);
      check(cfg_o, cfg_exp[i]);
    end
    send(8'h80, 32'h0000000A);
    check(station_fc_o, 4'hA);
    send(8'h81, 32'h00000100);
    check(station_ptr_o, 32'h00000100);
    $display("test config done");
    // Buffer store faults while the bus answers slowly
    @(posedge clk_i);
    err_en   <= 1'b1;
    err_addr <= 32'h00000053;
    wait_n   <= 2'h2;
    st_ptr   <= 32'h00000020;
    st_fc    <= 4'h3;
    send(8'h86, 32'h00000000);
    check(rx_enable_o, 1'b1);
    rx_put(1'b0, 8'hA5);
    wait_log(4);
    check(rx_enable_o, 1'b0);
    check(rx_status_o[0], 1'b1);
    chk_log(2, 32'h00000144, 16'h0053);
    check(mem_model_inst.log_addr[0], 32'h00000140);
    check(mem_model_inst.log_addr[3], 32'h00000146);
    $display("test bus_error done");
    // Host reloads the table, bus answers promptly
    @(posedge clk_i);
    err_en <= 1'b0;
    wait_n <= 2'h0;
    send(8'h86, 32'h00000000);
    rx_put(1'b0, 8'hA5);
    rx_put(1'b0, 8'h3C);
    rx_put(1'b1, 8'h00);
    wait_log(7);
    chk_log(4, 32'h00000053, 16'hA5A5);
    check(mem_model_inst.log_fc[4], 4'h5);
    chk_log(5, 32'h00000054, 16'h3C3C);
    chk_log(6, 32'h00000028, 16'h0001);
    $display("test receive done");
    // Linked table on a 16-bit bus with bursts capped at eight cycles
    send(8'hC9, 32'h00000000);
    check(cfg_o, 6'h05);
    @(posedge clk_i);
    st_ptr <= 32'h00000030;
    st_fc  <= 4'h6;
    send(8'h86, 32'h00000000);
    rx_put(1'b0, 8'h11);
    rx_put(1'b0, 8'h22);
    rx_put(1'b0, 8'h33);
    rx_put(1'b1, 8'h00);
    wait_log(11);
    chk_log(7, 32'h00000060, 16'h1111);
    chk_log(8, 32'h00000061, 16'h2222);
    chk_log(9, 32'h00000062, 16'h3333);
    chk_log(10, 32'h00000038, 16'h0000);
    check(mem_model_inst.log_up[7], 1'b1);
    check(mem_model_inst.log_up[8], 1'b0);
    check(mem_model_inst.log_fc[9], 4'h6);
    rx_put(1'b0, 8'h44);
    wait_log(12);
    check(rx_enable_o, 1'b1);
    chk_log(11, 32'h00000070, 16'h4444);
    check(mem_model_inst.log_fc[11], 4'h7);
    $display("test linked_table done");
    // Reset command stalls until the transmit clock runs
    @(posedge clk_i);
    tx_clk_running_i <= 1'b0;
    fork
      send(8'hFF, 32'h00000000);
      begin
        repeat (20) @(posedge clk_i);
        #1 check(semaphore_o, 8'hFE);
        @(posedge clk_i);
        tx_clk_running_i <= 1'b1;
      end
    join
    check(station_fc_o, 4'h0);
    check(station_ptr_o, 32'h00000000);
    check(cfg_o, 6'h00);
    check(rx_status_o, 3'h0);
    check(int_vector_o, 8'h0F);
    check(rx_enable_o, 1'b0);
    check(mem_req_o, 1'b0);
    check(line_idle_o, 1'b1);
    check(rx_byte_ready_o, 1'b0);
    $display("test reset_command done");
    test_done();
  end
endmodule : hdlc_cmd_rx_tb
